//--- hdl/pciu_top.sv
// pin change interrupt unit: 32 pins in four groups of eight
// assumes the cpu core supplies the global interrupt enable and a
// per-group vector-taken pulse when a group's routine begins
//
// Operation
// - group 2 pins 23..16 request interrupt
// - group 1 pins 15..8 request interrupt
// - group 0 pins 7..0 request interrupt
// - group 3 pins 31..24 request interrupt
// - group enables in control bits 3..0
// - each group owns its own vector
// - change on enabled pin sets group flag
// - flag, enable, global enable give branch
// - taking the vector clears the flag
// - write one clears flag, zero keeps
// - pin needs mask and group enable
// - masked-off pin never sets flag
// - group 3 mask gates pins 31..24
// - flags also at i/o address 0x1b
`timescale 1ns/100ps
module pciu_top (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // pins
  input wire logic [31:0] change_sense_input_in,
  // cpu register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_io_space_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // core interrupt handshake
  input wire logic global_int_enable_in,
  input wire logic [3:0] vector_taken_in,
  output logic [3:0] vector_request_out
);

  pciu_pkg::pciu_bus_req_type req;
  pciu_pkg::pciu_state_type st_r;
  pciu_pkg::pciu_state_type st_nxt;
  logic [7:0] daddr;
  logic [pciu_pkg::NUM_PINS-1:0] edges;
  logic [pciu_pkg::NUM_GROUPS-1:0] change;

  assign req.wr = reg_wr_in;
  assign req.rd = reg_rd_in;
  assign req.io_space = reg_io_space_in;
  assign req.addr = reg_addr_in;
  assign req.wdata = reg_wdata_in;

  // ==========================================================
  // address mapping
  // i/o space address lifted into data space
  assign daddr = req.io_space ? 8'(req.addr + pciu_pkg::IO_SPACE_OFS) : req.addr;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  // ==========================================================
  // change detection per group
  assign edges = st_r.sync2 ^ st_r.prev;

  for (genvar g = 0; g < pciu_pkg::NUM_GROUPS; g++) begin : gen_group
    // pin counts only with mask bit and group enable
    assign change[g] = st_r.enable[g] &
      (|(edges[g*8 +: 8] & st_r.mask[g*8 +: 8]));
  end

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = change_sense_input_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    // register writes
    if (req.wr) begin
      if (hit(daddr, pciu_pkg::ADDR_CTRL)) begin
        st_nxt.enable = req.wdata[3:0];
      end
      if (hit(daddr, pciu_pkg::ADDR_MASK0)) begin
        st_nxt.mask[7:0] = req.wdata;
      end
      if (hit(daddr, pciu_pkg::ADDR_MASK1)) begin
        st_nxt.mask[15:8] = req.wdata;
      end
      if (hit(daddr, pciu_pkg::ADDR_MASK2)) begin
        st_nxt.mask[23:16] = req.wdata;
      end
      if (hit(daddr, pciu_pkg::ADDR_MASK3)) begin
        st_nxt.mask[31:24] = req.wdata;
      end
      if (hit(daddr, pciu_pkg::ADDR_FLAGS)) begin
        st_nxt.flags = st_nxt.flags & ~req.wdata[3:0];
      end
    end
    // vector taken clears; a new change in the same cycle wins
    st_nxt.flags = (st_nxt.flags & ~vector_taken_in) | change;
    // per-group request toward the core
    st_nxt.request = st_nxt.flags & st_nxt.enable & {4{global_int_enable_in}};
    // read data
    st_nxt.rdata = 8'h00;
    if (req.rd) begin
      case (daddr)
        pciu_pkg::ADDR_CTRL: begin
          st_nxt.rdata = {4'h0, st_r.enable};
        end
        pciu_pkg::ADDR_FLAGS: begin
          st_nxt.rdata = {4'h0, st_r.flags};
        end
        pciu_pkg::ADDR_MASK0: begin
          st_nxt.rdata = st_r.mask[7:0];
        end
        pciu_pkg::ADDR_MASK1: begin
          st_nxt.rdata = st_r.mask[15:8];
        end
        pciu_pkg::ADDR_MASK2: begin
          st_nxt.rdata = st_r.mask[23:16];
        end
        pciu_pkg::ADDR_MASK3: begin
          st_nxt.rdata = st_r.mask[31:24];
        end
        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_out = st_r.rdata;
  assign vector_request_out = st_r.request;

  // ==========================================================
  // checks
  AST_FLAG_SET: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_r.enable[0] && |(edges[7:0] & st_r.mask[7:0]))
    |=> st_r.flags[0]) else $error("group 0 flag not set on change");
  AST_MASKED_QUIET: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_r.mask[31:24] == 8'h00 && !st_r.flags[3] && !(req.wr))
    |=> !st_r.flags[3]) else $error("masked group 3 flag rose");
  AST_NO_ENABLE_QUIET: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (!st_r.enable[1] && !st_r.flags[1]) |=> !st_r.flags[1])
    else $error("disabled group 1 flag rose");
  AST_W1C: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (req.wr && !req.io_space && req.addr == pciu_pkg::ADDR_FLAGS && req.wdata[2] &&
     !(st_r.enable[2] && |((st_r.sync2[23:16] ^ st_r.prev[23:16]) & st_r.mask[23:16])))
    |=> !st_r.flags[2]) else $error("write one did not clear flag 2");
  AST_TAKEN_CLEAR: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (vector_taken_in[3] && !(st_r.enable[3] &&
     |((st_r.sync2[31:24] ^ st_r.prev[31:24]) & st_r.mask[31:24])))
    |=> !st_r.flags[3]) else $error("vector taken did not clear flag 3");
  AST_REQUEST: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    vector_request_out == (st_r.flags & st_r.enable & {4{$past(global_int_enable_in)}}))
    else $error("request differs from flag and enables");
  AST_GIE_OFF: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !global_int_enable_in |=> vector_request_out == 4'h0)
    else $error("request with global enable off");
  AST_SYNC: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $past(rst_n_in, 2) |-> st_r.sync2 == $past(change_sense_input_in, 2))
    else $error("sync delay not two cycles");
  AST_UPPER_ZERO: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $past(req.rd) && $past(daddr) == pciu_pkg::ADDR_FLAGS |-> reg_rdata_out[7:4] == 4'h0)
    else $error("flag upper bits not zero");

  // flag set, one per group
  AST_FLAG_SET_G1: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_r.enable[1] && |(edges[15:8] & st_r.mask[15:8])) |=> st_r.flags[1])
    else $error("group 1 flag not set on change");
  AST_FLAG_SET_G2: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_r.enable[2] && |(edges[23:16] & st_r.mask[23:16])) |=> st_r.flags[2])
    else $error("group 2 flag not set on change");
  AST_FLAG_SET_G3: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_r.enable[3] && |(edges[31:24] & st_r.mask[31:24])) |=> st_r.flags[3])
    else $error("group 3 flag not set on change");

  // register writes and reads
  AST_CTRL_WRITE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (req.wr && daddr == pciu_pkg::ADDR_CTRL) |=> st_r.enable == $past(req.wdata[3:0]))
    else $error("control write not taken");
  AST_MASK0_WRITE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (req.wr && daddr == pciu_pkg::ADDR_MASK0) |=> st_r.mask[7:0] == $past(req.wdata))
    else $error("mask 0 write not taken");
  AST_MASK3_WRITE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (req.wr && daddr == pciu_pkg::ADDR_MASK3) |=> st_r.mask[31:24] == $past(req.wdata))
    else $error("mask 3 write not taken");
  AST_READ_FLAGS: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ($past(req.rd) && $past(daddr) == pciu_pkg::ADDR_FLAGS)
    |-> reg_rdata_out[3:0] == $past(st_r.flags))
    else $error("flag read differs from flags");

  // clears and request
  AST_IO_CLEAR: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (req.wr && req.io_space && req.addr == 8'(pciu_pkg::ADDR_FLAGS - pciu_pkg::IO_SPACE_OFS) &&
     req.wdata[2] && !change[2]) |=> !st_r.flags[2])
    else $error("short address write did not clear flag 2");
  AST_ZERO_KEEPS: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (req.wr && daddr == pciu_pkg::ADDR_FLAGS && !req.wdata[0] && st_r.flags[0] &&
     !vector_taken_in[0]) |=> st_r.flags[0])
    else $error("write zero cleared flag 0");
  AST_TAKEN_CLEAR_G1: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (vector_taken_in[1] && !change[1]) |=> !st_r.flags[1])
    else $error("vector taken did not clear flag 1");
  AST_ONE_VECTOR: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (vector_request_out & ~st_r.flags) == 4'h0)
    else $error("request without its own flag");
  AST_RISE_NEEDS_EDGE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_r.flags & ~$past(st_r.flags) & ~$past(change)) == 4'h0)
    else $error("flag rose without a change");

endmodule

//--- hdl/pciu_pkg.sv
// pin change interrupt unit: register map, field layout, carriers
// assumes a byte-wide cpu data-space register port on the system clock
package pciu_pkg;

  // ==========================================================
  // register addresses (data space)
  localparam logic [7:0] ADDR_CTRL = 8'h68;
  localparam logic [7:0] ADDR_FLAGS = 8'h3b;
  localparam logic [7:0] ADDR_MASK0 = 8'h6b;
  localparam logic [7:0] ADDR_MASK1 = 8'h6c;
  localparam logic [7:0] ADDR_MASK2 = 8'h6d;
  localparam logic [7:0] ADDR_MASK3 = 8'h73;
  // short i/o space sits this far below data space
  localparam logic [7:0] IO_SPACE_OFS = 8'h20;

  // ==========================================================
  // fields and reset values
  localparam int NUM_GROUPS = 4;
  localparam int GROUP_W = 8;
  localparam int NUM_PINS = 32;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] GROUP_FIELD = 8'h0f;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic io_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pciu_bus_req_type;

  typedef struct packed {
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] prev;
    logic [3:0] enable;
    logic [3:0] flags;
    logic [NUM_PINS-1:0] mask;
    logic [7:0] rdata;
    logic [3:0] request;
  } pciu_state_type;

endpackage

//--- bench/pciu_pin_model.sv
// pin model: levels on the 32 change-sense pins
// assumes the bench asks for toggles at the falling clock edge
`timescale 1ns/100ps
module pciu_pin_model (
  // clock
  input wire logic clk_in,
  // toggle request, one bit per pin
  input wire logic [31:0] flip_in,
  // pin levels
  output logic [31:0] pins_out
);
  logic [31:0] level = 32'h0000_0000;
  assign pins_out = level;
  // pins move away from the sampling edge
  always @(negedge clk_in) begin
    level <= level ^ flip_in;
  end
endmodule

//--- bench/testbench.sv
// testbench for the pin change interrupt unit
// assumes pciu_pkg and pciu_top are compiled first
`timescale 1ns/100ps
module testbench;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, io = 0, gie = 1;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
  logic [31:0] flip = 32'h0000_0000, pins;
  logic [3:0] vt = 4'h0, req;
  logic [7:0] maddr [4] = '{pciu_pkg::ADDR_MASK0, pciu_pkg::ADDR_MASK1,
    pciu_pkg::ADDR_MASK2, pciu_pkg::ADDR_MASK3};
  int n_errors = 0, tests_run = 0, cyc = 0;
  always #25 clk = ~clk;
  pciu_pin_model pciu_pin_model_inst (.clk_in(clk), .flip_in(flip), .pins_out(pins));
  pciu_top pciu_top_inst (.core_clk_in(clk), .rst_n_in(rst_n),
    .change_sense_input_in(pins), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_io_space_in(io), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_rdata_out(rdat), .global_int_enable_in(gie),
    .vector_taken_in(vt), .vector_request_out(req));
  // ==========================================
  // tasks
  task report_and_stop;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  task acc(input logic w, input logic s, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr <= w;
    rd <= !w;
    io <= s;
    addr <= a;
    wd <= d;
    @(negedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task rdc(input logic s, input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, s, a, 8'h00);
    chk(rdat, e);
  endtask
  task tog(input logic [31:0] m);
    @(negedge clk);
    flip <= m;
    @(negedge clk);
    flip <= 32'h0000_0000;
    repeat (6) @(negedge clk);
  endtask
  // ==========================================
  // timeout
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop;
    end
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_n <= 1'b1;
    rdc(0, pciu_pkg::ADDR_CTRL, 8'h00);
    rdc(0, pciu_pkg::ADDR_FLAGS, 8'h00);
    for (int g = 0; g < 4; g++) rdc(0, maddr[g], 8'h00);
    acc(1, 0, pciu_pkg::ADDR_CTRL, 8'h0f);
    rdc(0, pciu_pkg::ADDR_CTRL, 8'h0f);
    for (int g = 0; g < 4; g++) begin
      acc(1, 0, maddr[g], 8'h80);
      rdc(0, maddr[g], 8'h80);
      tog(32'h0000_0001 << (8 * g + 6));
      rdc(0, pciu_pkg::ADDR_FLAGS, 8'h00);
      tog(32'h0000_0001 << (8 * g + 7));
      rdc(0, pciu_pkg::ADDR_FLAGS, 8'h01 << g);
      chk({4'h0, req}, 8'h01 << g);
      acc(1, 0, pciu_pkg::ADDR_FLAGS, 8'h00);
      rdc(0, pciu_pkg::ADDR_FLAGS, 8'h01 << g);
      if (g[0]) begin
        @(negedge clk);
        vt <= 4'h1 << g;
        @(negedge clk);
        vt <= 4'h0;
      end
      else acc(1, g == 2, 8'h3b - (g == 2 ? 8'h20 : 8'h00), 8'h01 << g);
      rdc(g == 2, 8'h1b + (g == 2 ? 8'h00 : 8'h20), 8'h00);
      chk({4'h0, req}, 8'h00);
    end
    gie <= 1'b0;
    tog(32'h0000_0080);
    rdc(0, pciu_pkg::ADDR_FLAGS, 8'h01);
    chk({4'h0, req}, 8'h00);
    acc(1, 0, pciu_pkg::ADDR_FLAGS, 8'hff);
    rdc(0, pciu_pkg::ADDR_FLAGS, 8'h00);
    acc(1, 0, pciu_pkg::ADDR_CTRL, 8'h00);
    tog(32'h0000_0080);
    rdc(0, pciu_pkg::ADDR_FLAGS, 8'h00);
    rdc(0, 8'h70, 8'h00);
    // low pin of group 3, then a reset in mid-run
    acc(1, 0, pciu_pkg::ADDR_MASK3, 8'hff);
    acc(1, 0, pciu_pkg::ADDR_CTRL, 8'h08);
    tog(32'h0100_0000);
    rdc(0, pciu_pkg::ADDR_FLAGS, 8'h08);
    chk({4'h0, req}, 8'h00);
    @(negedge clk);
    rst_n <= 1'b0;
    repeat (3) @(negedge clk);
    rst_n <= 1'b1;
    rdc(0, pciu_pkg::ADDR_CTRL, 8'h00);
    rdc(0, pciu_pkg::ADDR_MASK3, 8'h00);
    rdc(0, pciu_pkg::ADDR_FLAGS, 8'h00);
    chk({4'h0, req}, 8'h00);
    report_and_stop;
  end
endmodule
